/* File: rtl/dps_pkg.sv */
package dps_pkg;
    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int NV_WRITE_MS = 20;
    localparam int NS_PER_MS = 1000000;
    // longest time, rounds down
    localparam int NV_WRITE_CYC = (NV_WRITE_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W = 22;

    // ************************************************
    // protocol
    // ************************************************
    // identification byte: arbitrary value
    localparam logic [7:0] ID_DEFAULT = 8'hA0;
    localparam logic [3:0] OP_READ = 4'hB;
    localparam logic [3:0] OP_WRITE = 4'hC;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    // synchroniser vector positions
    localparam int PIN_CS = 2;
    localparam int PIN_SCK = 1;
    localparam int PIN_SDI = 0;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [3:0] ADDR_WIPER0 = 4'h0;
    localparam logic [3:0] ADDR_WIPER1 = 4'h1;
    localparam logic [3:0] ADDR_GP_FIRST = 4'h2;
    localparam logic [3:0] ADDR_GP_LAST = 4'h6;
    localparam logic [3:0] ADDR_WRAP = 4'h0;
    localparam logic [3:0] ADDR_ACCESS = 4'h8;
    localparam logic [3:0] ADDR_STEP = 4'h1;
    localparam int ACC_SEL_BIT = 7;
    localparam int ACC_SHUT_BIT = 6;
    localparam logic ACC_SEL_RST = 1'b0;
    localparam logic ACC_SHUT_RST = 1'b1;
    localparam logic [4:0] ACC_RSVD = 5'h0;
    localparam logic [7:0] WIPER_INIT = 8'h40;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ************************************************
    // buffer and states
    // ************************************************
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [1:0] BUF_ONE = 2'h1;

    typedef enum logic [2:0] {
        ST_ID = 3'b000,
        ST_CMD = 3'b001,
        ST_READ = 3'b011,
        ST_WRITE = 3'b010,
        ST_SKIP = 3'b110
    } dps_state_e;
endpackage

/* File: rtl/dps_spi_pot.sv */
`timescale 1ns/1ps
module dps_spi_pot #(
    parameter int unsigned NV_WRITE_CYCLES = dps_pkg::NV_WRITE_CYC,
    parameter logic [7:0] DEVICE_ID = dps_pkg::ID_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // spi pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    output logic spi_sdo_o,
    output logic spi_sdo_oe,
    // potentiometer side
    output logic [6:0] wiper0_pos,
    output logic [6:0] wiper1_pos,
    output logic shutdown_control,
    output logic nv_write_busy
);
    // ************************************************
    // pin synchronisers and edges
    // ************************************************
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic [2:0] pin_prev_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_q <= 3'h4;
            pin_sync_q <= 3'h4;
            pin_prev_q <= 3'h4;
        end else begin
            pin_meta_q <= {spi_cs_n, spi_sck, spi_sdi};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    wire cs_act = ~pin_sync_q[dps_pkg::PIN_CS];
    wire sdi_bit = pin_sync_q[dps_pkg::PIN_SDI];
    // sck edges only count while selected
    wire sck_rise = cs_act & pin_sync_q[dps_pkg::PIN_SCK]
        & ~pin_prev_q[dps_pkg::PIN_SCK];
    wire sck_fall = cs_act & ~pin_sync_q[dps_pkg::PIN_SCK]
        & pin_prev_q[dps_pkg::PIN_SCK];
    wire cs_rise = pin_sync_q[dps_pkg::PIN_CS] & ~pin_prev_q[dps_pkg::PIN_CS];

    // ************************************************
    // receive shifter and sequencing
    // ************************************************
    dps_pkg::dps_state_e state_q;
    dps_pkg::dps_state_e state_d;
    logic [7:0] rx_q;
    logic [2:0] bit_cnt_q;
    logic [3:0] addr_q;

    wire [7:0] rx_byte = {rx_q[6:0], sdi_bit};
    wire byte_done = sck_rise && (bit_cnt_q == dps_pkg::BIT_LAST);
    wire [3:0] op_field = rx_byte[7:4];
    wire [3:0] addr_field = rx_byte[3:0];
    wire cmd_done = byte_done && (state_q == dps_pkg::ST_CMD);
    wire go_read = cmd_done && (op_field == dps_pkg::OP_READ);
    wire go_write = cmd_done && (op_field == dps_pkg::OP_WRITE);
    wire id_ok = rx_byte == DEVICE_ID;

    always_comb begin
        state_d = state_q;
        case (state_q)
            dps_pkg::ST_ID: begin
                if (byte_done) begin
                    state_d = id_ok ? dps_pkg::ST_CMD
                        : dps_pkg::ST_SKIP;
                end
            end
            dps_pkg::ST_CMD: begin
                if (go_read) begin
                    state_d = dps_pkg::ST_READ;
                end else if (go_write) begin
                    state_d = dps_pkg::ST_WRITE;
                end else if (byte_done) begin
                    state_d = dps_pkg::ST_SKIP;
                end
            end
            dps_pkg::ST_READ: state_d = dps_pkg::ST_READ;
            dps_pkg::ST_WRITE: state_d = dps_pkg::ST_WRITE;
            dps_pkg::ST_SKIP: state_d = dps_pkg::ST_SKIP;
            default: state_d = dps_pkg::ST_ID;
        endcase
        if (cs_rise) begin
            state_d = dps_pkg::ST_ID;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= dps_pkg::ST_ID;
            rx_q <= dps_pkg::READ_ZERO;
            bit_cnt_q <= dps_pkg::BIT_FIRST;
        end else begin
            state_q <= state_d;
            if (cs_rise) begin
                bit_cnt_q <= dps_pkg::BIT_FIRST;
            end else if (sck_rise) begin
                rx_q <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
        end
    end

    // ************************************************
    // register file
    // ************************************************
    logic [7:0] live_q [0:1];
    logic [7:0] pwr_q [0:1];
    logic [7:0] gp_q [2:6];
    logic dsel_q;
    logic shut_q;
    logic busy_q;
    logic nv_pend_q;
    logic [dps_pkg::BUSY_CNT_W-1:0] busy_cnt_q;

    wire is_wiper = (addr_q == dps_pkg::ADDR_WIPER0)
        || (addr_q == dps_pkg::ADDR_WIPER1);
    wire is_gp = (addr_q >= dps_pkg::ADDR_GP_FIRST)
        && (addr_q <= dps_pkg::ADDR_GP_LAST);
    wire is_acc = addr_q == dps_pkg::ADDR_ACCESS;
    wire [7:0] acc_rd = {dsel_q, shut_q, busy_q,
        dps_pkg::ACC_RSVD};
    // live or power-on copy by direct select; reads never alter live
    wire [7:0] wiper_rd = dsel_q ? live_q[addr_q[0]]
        : pwr_q[addr_q[0]];
    wire [7:0] rd_data = is_wiper ? wiper_rd
        : is_gp ? gp_q[addr_q[2:0]]
        : is_acc ? acc_rd : dps_pkg::READ_ZERO;
    // busy blocks every write, not only non-volatile ones
    wire wr_en = byte_done && (state_q == dps_pkg::ST_WRITE)
        && !busy_q;
    wire wr_nv = wr_en && ((is_wiper && !dsel_q) || is_gp);
    wire [3:0] addr_next = (addr_q >= dps_pkg::ADDR_GP_LAST)
        ? dps_pkg::ADDR_WRAP : addr_q + dps_pkg::ADDR_STEP;

    // power-up recall: reset loads both copies from the same value
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            live_q <= '{dps_pkg::WIPER_INIT, dps_pkg::WIPER_INIT};
            pwr_q <= '{dps_pkg::WIPER_INIT, dps_pkg::WIPER_INIT};
        end else if (wr_en && is_wiper) begin
            live_q[addr_q[0]] <= rx_byte;
            if (!dsel_q) begin
                pwr_q[addr_q[0]] <= rx_byte;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gp_q <= '{default: dps_pkg::READ_ZERO};
            dsel_q <= dps_pkg::ACC_SEL_RST;
            shut_q <= dps_pkg::ACC_SHUT_RST;
        end else if (wr_en && is_gp) begin
            gp_q[addr_q[2:0]] <= rx_byte;
        end else if (wr_en && is_acc) begin
            dsel_q <= rx_byte[dps_pkg::ACC_SEL_BIT];
            shut_q <= rx_byte[dps_pkg::ACC_SHUT_BIT];
        end
    end

    // non-volatile cycle starts once chip select returns high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            nv_pend_q <= 1'b0;
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
        end else begin
            if (cs_rise) begin
                nv_pend_q <= 1'b0;
            end else if (wr_nv) begin
                nv_pend_q <= 1'b1;
            end
            if (cs_rise && nv_pend_q) begin
                busy_q <= 1'b1;
                busy_cnt_q <= dps_pkg::BUSY_CNT_W'(NV_WRITE_CYCLES - 1);
            end else if (busy_q) begin
                busy_q <= busy_cnt_q != '0;
                busy_cnt_q <= busy_cnt_q - 1'b1;
            end
        end
    end

    // ************************************************
    // read fetch and two-entry buffer
    // ************************************************
    logic [7:0] buf_mem_q [0:1];
    logic buf_wr_q;
    logic buf_rd_q;
    logic [1:0] buf_cnt_q;

    wire buf_ready = buf_cnt_q != dps_pkg::BUF_DEPTH;
    wire buf_valid = buf_cnt_q != 2'h0;
    wire buf_push = (state_q == dps_pkg::ST_READ) && buf_ready
        && !cs_rise;
    wire tx_load = sck_fall && (state_q == dps_pkg::ST_READ)
        && (bit_cnt_q == dps_pkg::BIT_FIRST);
    wire buf_pop = tx_load && buf_valid;
    wire buf_flush = cs_rise || go_read;

    // pointer advances per fetched byte, stalls when buffer is full
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= dps_pkg::ADDR_WRAP;
        end else if (cmd_done) begin
            addr_q <= addr_field;
        end else if (buf_push || wr_en) begin
            addr_q <= addr_next;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            buf_mem_q <= '{dps_pkg::READ_ZERO, dps_pkg::READ_ZERO};
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else if (buf_flush) begin
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_mem_q[buf_wr_q] <= rd_data;
                buf_wr_q <= ~buf_wr_q;
            end
            if (buf_pop) begin
                buf_rd_q <= ~buf_rd_q;
            end
            if (buf_push && !buf_pop) begin
                buf_cnt_q <= buf_cnt_q + dps_pkg::BUF_ONE;
            end else if (buf_pop && !buf_push) begin
                buf_cnt_q <= buf_cnt_q - dps_pkg::BUF_ONE;
            end
        end
    end

    // ************************************************
    // transmit shifter and open-drain sdo
    // ************************************************
    logic [7:0] tx_q;
    logic tx_live_q;
    logic sdo_oe_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= dps_pkg::READ_ZERO;
            tx_live_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else begin
            if (cs_rise) begin
                tx_live_q <= 1'b0;
            end else if (buf_pop) begin
                tx_q <= buf_mem_q[buf_rd_q];
                tx_live_q <= 1'b1;
            end else if (sck_fall) begin
                tx_q <= {tx_q[6:0], 1'b1};
            end
            // pull low only for a zero bit while selected in a read
            sdo_oe_q <= cs_act && tx_live_q && !cs_rise
                && (state_q == dps_pkg::ST_READ)
                && !tx_q[7];
        end
    end

    assign spi_sdo_o = 1'b0;
    assign spi_sdo_oe = sdo_oe_q;
    assign wiper0_pos = live_q[0][6:0];
    assign wiper1_pos = live_q[1][6:0];
    assign shutdown_control = shut_q;
    assign nv_write_busy = busy_q;
endmodule

/* File: tb/dps_host.sv */
`timescale 1ns/1ps
module dps_host (
    // clock
    input wire logic core_clk,
    // spi pins
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end
    // half an sck period of 64 ns
    task automatic half();
        repeat (4) @(negedge core_clk);
    endtask
    // sampled late in the low phase: device bit changes ~4 clk after fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_sdi = tx[i];
            half();
            rx[i] = spi_sdo;
            spi_sck = 1'b1;
            half();
            spi_sck = 1'b0;
        end
    endtask
    task automatic start_frame(input logic [7:0] id, ins);
        logic [7:0] rx;
        spi_cs_n = 1'b0;
        half();
        xfer(id, rx);
        xfer(ins, rx);
    endtask
    task automatic end_frame();
        half();
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        half();
        half();
    endtask
endmodule

/* File: tb/dps_spi_pot_asserts.sv */
`timescale 1ns/1ps
module dps_chk #(
    parameter int unsigned NV_WRITE_CYCLES = 20
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // spi pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    input wire logic spi_sdo_o,
    input wire logic spi_sdo_oe,
    // potentiometer side
    input wire logic [6:0] wiper0_pos,
    input wire logic [6:0] wiper1_pos,
    input wire logic shutdown_control,
    input wire logic nv_write_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // busy length counted, too long for a repetition
    logic [31:0] busy_len_q;
    logic [31:0] busy_len_d;
    assign busy_len_d = nv_write_busy ? busy_len_q + 32'h0000_0001 : '0;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) busy_len_q <= 32'h0000_0000;
        else busy_len_q <= busy_len_d;
    end
    a_sdo_idle_off: assert property (spi_cs_n [*6] |-> !spi_sdo_oe)
        else $error("sdo driven while deselected");
    a_sdo_pull_low: assert property (spi_sdo_o == 1'b0)
        else $error("sdo data level not low");
    a_sdo_steady_rise: assert property ($rose(spi_sck) && !spi_cs_n
        |=> $stable(spi_sdo_oe) [*3]) else $error("sdo moved near sck rise");
    a_wiper_idle_hold: assert property (spi_cs_n [*5]
        |-> $stable(wiper0_pos) && $stable(wiper1_pos))
        else $error("wiper moved while deselected");
    a_shut_idle_hold: assert property (spi_cs_n [*5]
        |-> $stable(shutdown_control)) else $error("shutdown moved idle");
    a_busy_freezes_regs: assert property (
        nv_write_busy && $past(nv_write_busy) |-> $stable(wiper0_pos)
        && $stable(wiper1_pos) && $stable(shutdown_control))
        else $error("register changed while busy");
    a_busy_after_cs: assert property ($rose(nv_write_busy)
        |-> $past(spi_cs_n, 2)) else $error("busy began inside a frame");
    a_busy_min_len: assert property ($rose(nv_write_busy)
        |-> nv_write_busy [*8]) else $error("busy too short");
    a_busy_max_len: assert property (
        busy_len_q <= NV_WRITE_CYCLES + 2) else $error("busy too long");
    c_sdo_pulled: cover property ($rose(spi_sdo_oe));
    c_busy_seen: cover property ($rose(nv_write_busy));
    c_wiper_moved: cover property ($changed(wiper0_pos));
    c_shut_low: cover property ($fell(shutdown_control));
endmodule
bind dps_spi_pot dps_chk #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) dps_chk_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck),
    .spi_sdi(spi_sdi),
    .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe(spi_sdo_oe),
    .wiper0_pos(wiper0_pos),
    .wiper1_pos(wiper1_pos),
    .shutdown_control(shutdown_control),
    .nv_write_busy(nv_write_busy)
);

/* File: tb/tb_dps_spi_pot.sv */
`timescale 1ns/1ps
module tb_dps_spi_pot;
    localparam logic [7:0] ID = dps_pkg::ID_DEFAULT;
    localparam logic [3:0] RD = dps_pkg::OP_READ;
    localparam logic [3:0] ACC = dps_pkg::ADDR_ACCESS;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    wire logic spi_cs_n, spi_sck, spi_sdi, spi_sdo;
    logic spi_sdo_o, spi_sdo_oe, shutdown_control, nv_write_busy;
    logic [6:0] wiper0_pos, wiper1_pos;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h0001_2A6D;
    logic [7:0] mem [16];
    logic [7:0] live [2];
    logic sel, shut;
    logic [7:0] id_now = ID;
    logic [7:0] d;
    // open drain with pull-up
    assign spi_sdo = spi_sdo_oe ? spi_sdo_o : 1'b1;
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    dps_spi_pot #(.NV_WRITE_CYCLES(600)) dps_spi_pot_inst (
        .core_clk(core_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o),
        .spi_sdo_oe(spi_sdo_oe), .wiper0_pos(wiper0_pos),
        .wiper1_pos(wiper1_pos), .shutdown_control(shutdown_control),
        .nv_write_busy(nv_write_busy));
    dps_host dps_host_inst (.core_clk(core_clk), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        if (a < 4'h2) return sel ? live[a[0]] : mem[a];
        if (a == ACC) return {sel, shut, 6'h00};
        return (a < 4'h7) ? mem[a] : 8'h00;
    endfunction
    task automatic check_val(input string what, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic [7:0] rx;
        dps_host_inst.start_frame(id_now, {dps_pkg::OP_WRITE, a});
        dps_host_inst.xfer(v, rx);
        dps_host_inst.end_frame();
        if (a == ACC) begin
            sel = v[7];
            shut = v[6];
        end else begin
            if (a < 4'h2) live[a[0]] = v;
            if (a > 4'h1 || !sel) mem[a] = v;
        end
    endtask
    task automatic rd(input logic [3:0] op, a, input int n);
        logic [7:0] rx;
        logic [7:0] e;
        logic [3:0] p;
        p = a;
        dps_host_inst.start_frame(id_now, {op, a});
        for (int i = 0; i < n; i++) begin
            dps_host_inst.xfer(rnd8(), rx);
            // refused frames leave sdo released, pulled up to ones
            e = (op == RD && id_now == ID) ? exp_rd(p) : 8'hFF;
            check_val("read", e, rx);
            p = (p >= 4'h6) ? 4'h0 : p + 4'h1;
        end
        dps_host_inst.end_frame();
    endtask
    task automatic wait_idle();
        logic [7:0] rx;
        for (int n = 0; n < 20; n++) begin
            dps_host_inst.start_frame(ID, {RD, ACC});
            dps_host_inst.xfer(8'h00, rx);
            dps_host_inst.end_frame();
            if (rx[5] === 1'b0) break;
        end
        check_val("busy", 8'h00, {7'h00, nv_write_busy});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        summarize();
    end
    initial begin
        foreach (mem[i]) mem[i] = (i < 2) ? 8'h40 : 8'h00;
        live[0] = 8'h40;
        live[1] = 8'h40;
        sel = 1'b0;
        shut = 1'b1;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) reset_n = 1'b1;
        check_val("wiper0", 8'h40, {1'b0, wiper0_pos});
        check_val("shutdown", 8'h01, {7'h00, shutdown_control});
        rd(RD, ACC, 2);
        $display("reset test done");
        for (int a = 2; a < 7; a++) begin
            wr(a[3:0], rnd8());
            wait_idle();
        end
        d = rnd8();
        rd(RD, {1'b0, d[2:0]}, 12);
        // unmapped address reads zero, then pointer wraps
        rd(RD, 4'hF, 2);
        $display("stream test done");
        wr(ACC, 8'h40);
        d = rnd8();
        wr(dps_pkg::ADDR_WIPER0, d);
        wait_idle();
        check_val("wiper0", {1'b0, d[6:0]}, {1'b0, wiper0_pos});
        wr(ACC, 8'hC0);
        d = rnd8();
        wr(dps_pkg::ADDR_WIPER1, d ^ 8'h01);
        wait_idle();
        check_val("wiper1", live[1] & 8'h7F, {1'b0, wiper1_pos});
        rd(RD, dps_pkg::ADDR_WIPER0, 2);
        wr(ACC, 8'h40);
        rd(RD, dps_pkg::ADDR_WIPER0, 2);
        check_val("wiper1", live[1] & 8'h7F, {1'b0, wiper1_pos});
        $display("select test done");
        wr(ACC, 8'h80);
        check_val("shutdown", 8'h00, {7'h00, shutdown_control});
        wr(4'h3, rnd8());
        check_val("busy", 8'h01, {7'h00, nv_write_busy});
        wr(ACC, 8'h40);
        // refused while busy: model goes back to the standing value
        sel = 1'b1;
        shut = 1'b0;
        wait_idle();
        rd(RD, ACC, 1);
        $display("busy test done");
        id_now = ID ^ 8'h01;
        rd(RD, ACC, 1);
        id_now = ID;
        rd(4'hE, 4'h0, 1);
        $display("refusal test done");
        summarize();
    end
endmodule
